// file: shared/adcoi_pkg.sv
// constants, types and helpers for the converter output interface
// assumes a 10 MHz system clock; all pins arrive asynchronously
//
// Summary of operation
// - format select low levels enable serial pins
// - sixteen bit word: two zeros, result msb first
// - data changes after serial clock rise
// - strobe falls at start, first bit ready
// - serial lines are open drain, pulled up
// - serial clock follows master conversion clock
// - minus five continuous, zero volts gated clock
// - serial-only part: style input picks clocking
// - start pulse rising edge starts, holds sample
// - start-pulse mode: status is active-low interrupt
// - read access falling edge clears interrupt
// - power-up interrupt low; dummy read clears
// - parallel format: whole word, no serial
// - byte read picks half by select input
// - chip-select mode: select falling starts conversion
// - chip-select mode: status is busy, low throughout
// - one read starts, waits, returns word
// - low byte first stalls, high byte plain
// - serial behaviour same in both modes
// - conversion lasts nineteen or twenty clock rises
// - high byte right-justified, top two zero
`default_nettype none

package adcoi_pkg;
  // result and serial word shape
  localparam int RES_W = 14;
  localparam int WORD_W = 16;
  localparam int LEAD_W = WORD_W - RES_W;
  localparam int BYTE_W = 8;
  localparam int HIGH_W = RES_W - BYTE_W;
  localparam int PAD_W = BYTE_W - HIGH_W;
  localparam int BIT_W = 4;
  // conversion length in master clock rises
  localparam int CONV_EDGES = 19;
  localparam int CONV_EDGES_SLOW = 20;
  localparam int EDGE_W = 5;
  // late-start window against clock rate
  localparam int CLK_PERIOD_NS = 100;
  localparam int START_WIN_NS = 30;
  localparam int START_WIN_CYC = (START_WIN_NS / CLK_PERIOD_NS < 1) ?
    1 : START_WIN_NS / CLK_PERIOD_NS;
  // format select pin levels
  localparam logic [1:0] FMT_GATED = 2'h0; // 0 V
  localparam logic [1:0] FMT_CONT = 2'h1;  // -5 V
  localparam logic [1:0] FMT_PAR = 2'h2;   // +5 V
  // synchroniser width: every pin that enters except sample_in
  localparam int SYNC_W = 9;
  // buffer in the result path
  localparam int BUF_DEPTH = 2;

  // converter sequencer states
  typedef enum logic [1:0] {
    ADCOI_IDLE,
    ADCOI_CONV
  } adcoi_state_t;
endpackage

`default_nettype wire

// file: design/adcoi_buf.sv
// small result buffer: valid/ready on both sides
// assumes both sides run on the same clock
`default_nettype none

module adcoi_buf #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH]; // storage flops
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q; // words held

  // pointer step with wrap at depth
  function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p);
    step = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;

  assign in_ready = (count_q != CNT_W'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= step(wr_ptr_q);
      if (pop) rd_ptr_q <= step(rd_ptr_q);
      count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
    end
  end
endmodule

`default_nettype wire

// file: design/adcoi_core.sv
// converter control and result output logic
// assumes pins are asynchronous; master clock sampled at 10 MHz
// open-drain lines: oe high pulls low, pull-ups are external
`default_nettype none

module adcoi_core
  import adcoi_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mclk,
  input wire logic start_pulse_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic upper_byte_sel,
  input wire logic [1:0] fmt_sel,
  input wire logic serial_only,
  input wire logic clk_style,
  input wire logic [RES_W-1:0] sample_in,
  output logic track_hold,
  output logic status_n,
  output logic [BYTE_W-1:0] result_low_byte,
  output logic result_low_oe,
  output logic [HIGH_W-1:0] result_high,
  output logic result_high_oe,
  output logic serial_frame_n_o,
  output logic serial_frame_n_oe,
  output logic serial_clk_o,
  output logic serial_clk_oe,
  output logic serial_dout_o,
  output logic serial_dout_oe
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ////////////////////////////////////////////////////////////////////
  logic [SYNC_W-1:0] sync1_q; // first stage, read by sync2 only
  logic [SYNC_W-1:0] sync2_q; // safe copies
  // idle pin levels, so that no false edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE =
    {1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0};
  wire logic mclk_s;
  wire logic start_s;
  wire logic cs_s;
  wire logic rd_s;
  wire logic upper_byte_sel_s;
  wire logic [1:0] fmt_s;
  wire logic serial_only_s;
  wire logic clk_style_s;

  assign {mclk_s, start_s, cs_s, rd_s, upper_byte_sel_s, fmt_s, serial_only_s,
          clk_style_s} = sync2_q;

  // two flops on every pin except sample_in
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= {mclk, start_pulse_n, cs_n, rd_n, upper_byte_sel,
                  fmt_sel, serial_only, clk_style};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // edge detection and mode decode
  ////////////////////////////////////////////////////////////////////
  logic mclk_prev_q; // master clock one cycle ago
  logic start_prev_q;
  logic cs_prev_q;
  logic acc_prev_q; // read access one cycle ago
  // parallel pins only exist on the full part
  wire logic acc = ~cs_s & ~rd_s & ~serial_only_s;

  // previous samples for edges; idle levels at reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mclk_prev_q <= 1'h0;
      start_prev_q <= 1'h1;
      cs_prev_q <= 1'h1;
      acc_prev_q <= 1'h0;
    end else begin
      mclk_prev_q <= mclk_s;
      start_prev_q <= start_s;
      cs_prev_q <= cs_s;
      acc_prev_q <= acc;
    end
  end

  wire logic mclk_rise = mclk_s & ~mclk_prev_q;
  wire logic mclk_fall = ~mclk_s & mclk_prev_q;
  // a start pin held low selects chip-select mode
  wire logic mode_cs = ~start_s;
  wire logic acc_fall = acc & ~acc_prev_q;
  wire logic acc_end = ~acc & acc_prev_q;
  wire logic par_fmt = ~serial_only_s & (fmt_s == FMT_PAR);
  // serial-only part takes its clock style from its own pin
  wire logic cont_clk = serial_only_s ? clk_style_s :
                        (fmt_s == FMT_CONT);

  ////////////////////////////////////////////////////////////////////
  // conversion sequencer
  ////////////////////////////////////////////////////////////////////
  adcoi_state_t state_q;
  adcoi_state_t state_d;
  logic [EDGE_W-1:0] edge_cnt_q; // master rises since start
  logic slow_q; // start landed on a rise
  logic [RES_W-1:0] held_q; // sample frozen at hold
  logic buf_in_ready;
  logic buf_out_valid;
  logic [RES_W-1:0] buf_out_data;
  logic buf_pop;

  // last rise index of this conversion
  function automatic logic [EDGE_W-1:0] last_edge(input logic slow);
    last_edge = slow ? EDGE_W'(CONV_EDGES_SLOW - 1) :
                       EDGE_W'(CONV_EDGES - 1);
  endfunction

  // start-pulse mode: rising edge of the pulse
  wire logic start_m1 = ~mode_cs & start_s & ~start_prev_q;
  // chip-select mode: select falls with low byte chosen
  wire logic start_m2 = mode_cs & ~cs_s & cs_prev_q & ~upper_byte_sel_s &
                        ~serial_only_s;
  // second start mid conversion is ignored; a start while the buffer is full is dropped
  // serial-only part keeps no words, so it can never fill up
  wire logic start_go = (start_m1 | start_m2) &
                        (state_q == ADCOI_IDLE) &
                        (buf_in_ready | serial_only_s);
  // sampling granularity cannot see the window finer than a cycle
  wire logic late_start = mclk_rise & (START_WIN_CYC > 0);
  wire logic done = (state_q == ADCOI_CONV) & mclk_rise &
                    (edge_cnt_q == last_edge(slow_q));

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ADCOI_IDLE: begin
        if (start_go) state_d = ADCOI_CONV;
      end
      ADCOI_CONV: begin
        if (done) state_d = ADCOI_IDLE;
      end
      default: state_d = ADCOI_IDLE;
    endcase
  end

  // state, edge count and held sample
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ADCOI_IDLE;
      edge_cnt_q <= '0;
      slow_q <= 1'h0;
      held_q <= '0;
    end else begin
      state_q <= state_d;
      if (start_go) begin
        edge_cnt_q <= '0;
        slow_q <= late_start;
        held_q <= sample_in;
      end else if (mclk_rise) begin
        edge_cnt_q <= edge_cnt_q + EDGE_W'(1);
      end
    end
  end

  // hold while converting, track otherwise
  assign track_hold = (state_q == ADCOI_CONV);

  ////////////////////////////////////////////////////////////////////
  // serial word: same path in both start modes
  ////////////////////////////////////////////////////////////////////
  logic frame_q; // frame active, strobe low
  logic fell_q; // first falling clock edge seen
  logic [BIT_W-1:0] bit_q; // bit now presented
  logic sdout_q; // level of bit now presented
  logic frame_d;
  logic fell_d;
  logic [BIT_W-1:0] bit_d;
  logic sdout_d;

  // picks bit idx of the zero-led word, msb first
  function automatic logic word_bit(input logic [RES_W-1:0] res,
                                    input logic [BIT_W-1:0] idx);
    logic [WORD_W-1:0] w;
    w = {{LEAD_W{1'h0}}, res};
    word_bit = w[WORD_W - 1 - int'(idx)];
  endfunction

  wire logic advance = frame_q & fell_q & mclk_rise;
  wire logic last_bit = (bit_q == BIT_W'(WORD_W - 1));

  // serial sequencing, shared by both modes
  always_comb begin
    frame_d = frame_q;
    fell_d = fell_q;
    bit_d = bit_q;
    sdout_d = sdout_q;
    if (start_go & ~par_fmt) begin
      frame_d = 1'h1;
      fell_d = 1'h0;
      bit_d = '0;
      sdout_d = word_bit(sample_in, '0);
    end else if (frame_q) begin
      if (mclk_fall) fell_d = 1'h1;
      if (advance & last_bit) begin
        frame_d = 1'h0;
      end else if (advance) begin
        bit_d = bit_q + BIT_W'(1);
        sdout_d = word_bit(held_q, bit_d);
      end
      // never outlive the conversion
      if (done) frame_d = 1'h0;
    end
  end

  // serial registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_q <= 1'h0;
      fell_q <= 1'h0;
      bit_q <= '0;
      sdout_q <= 1'h0;
    end else begin
      frame_q <= frame_d;
      fell_q <= fell_d;
      bit_q <= bit_d;
      sdout_q <= sdout_d;
    end
  end

  // open-drain drivers: only ever pull low
  // gated clock opens on a real fall, else a mid-low start adds an edge
  wire logic sclk_run = ~par_fmt &
                        (cont_clk | (frame_q & (fell_q | mclk_fall)));
  assign serial_clk_o = 1'h0;
  // low half of master clock pulls the line down
  assign serial_clk_oe = sclk_run & ~mclk_s;
  assign serial_dout_o = 1'h0;
  assign serial_dout_oe = frame_q & ~sdout_q;
  assign serial_frame_n_o = 1'h0;
  assign serial_frame_n_oe = frame_q;

  ////////////////////////////////////////////////////////////////////
  // status pin: interrupt or busy
  ////////////////////////////////////////////////////////////////////
  logic status_low_q; // pin pulled low
  logic status_low_d;

  // set wins over clear in start-pulse mode
  always_comb begin
    status_low_d = status_low_q;
    if (mode_cs) begin
      if (start_go) status_low_d = 1'h1;
      else if (done) status_low_d = 1'h0;
    end else begin
      if (done) status_low_d = 1'h1;
      else if (acc_fall) status_low_d = 1'h0;
    end
  end

  // reset mimics a power-up conversion: low until a dummy read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_low_q <= 1'h1;
    end else begin
      status_low_q <= status_low_d;
    end
  end

  assign status_n = ~status_low_q;

  ////////////////////////////////////////////////////////////////////
  // result buffer and parallel read port
  ////////////////////////////////////////////////////////////////////
  logic [BYTE_W-1:0] low_q;
  logic [HIGH_W-1:0] high_q;
  logic served_q; // a word was shown in this access
  logic [1:0] got_q; // bytes delivered: {high, low}
  // no parallel reads on the serial-only part, so nothing is stored
  wire logic push_word = done & ~serial_only_s;

  adcoi_buf #(
    .WIDTH(RES_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(push_word),
    .in_ready(buf_in_ready),
    .in_data(held_q),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  // chip-select reads wait here until the word lands
  wire logic show = acc & buf_out_valid;
  wire logic [1:0] got_now = upper_byte_sel_s ? 2'h2 : 2'h1;
  wire logic [1:0] got_all = got_q | got_now;
  // parallel word leaves on one read, bytes after both halves
  assign buf_pop = acc_end & served_q &
                   (par_fmt | (got_all == 2'h3));
  wire logic [BYTE_W-1:0] byte_sel = (upper_byte_sel_s & ~par_fmt) ?
    {{PAD_W{1'h0}}, buf_out_data[RES_W-1:BYTE_W]} :
    buf_out_data[BYTE_W-1:0];

  // output data registers and byte bookkeeping
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_q <= '0;
      high_q <= '0;
      served_q <= 1'h0;
      got_q <= 2'h0;
    end else begin
      if (show) begin
        low_q <= byte_sel;
        high_q <= buf_out_data[RES_W-1:BYTE_W];
      end
      if (acc_end) served_q <= 1'h0;
      else if (show) served_q <= 1'h1;
      if (buf_pop) got_q <= 2'h0;
      else if (acc_end & served_q & ~par_fmt) got_q <= got_all;
    end
  end

  assign result_low_byte = low_q;
  assign result_high = high_q;
  assign result_low_oe = acc;
  // upper pins belong to the serial port unless parallel
  assign result_high_oe = acc & par_fmt;

  ////////////////////////////////////////////////////////////////////
  // checks
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_go_serial;
    start_go && !par_fmt;
  endsequence

  sequence s_busy_hold;
    status_low_q [*8];
  endsequence

  property p_frame_start;
    s_go_serial |=> frame_q && !sdout_q && bit_q == '0;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("strobe or first zero missing at start");

  property p_frame_end;
    done |=> !frame_q;
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("strobe still low after conversion");

  property p_par_quiet;
    start_go && par_fmt |=> !frame_q && !serial_dout_oe;
  endproperty
  a_par_quiet: assert property (p_par_quiet)
    else $error("serial frame in parallel format");

  property p_bit_step;
    advance && !last_bit |=> bit_q == $past(bit_q) + BIT_W'(1);
  endproperty
  a_bit_step: assert property (p_bit_step)
    else $error("serial bit did not step on rise");

  property p_int_set;
    !mode_cs && done |=> status_low_q;
  endproperty
  a_int_set: assert property (p_int_set)
    else $error("interrupt not raised at conversion end");

  property p_int_clear;
    !mode_cs && acc_fall && !done |=> !status_low_q;
  endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("interrupt not cleared by read");

  property p_busy;
    mode_cs && start_go |=> s_busy_hold;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy not held after start");

  property p_conv_len;
    done |-> edge_cnt_q == last_edge(slow_q) &&
             (slow_q || edge_cnt_q == EDGE_W'(CONV_EDGES - 1));
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

  property p_gated_clk;
    !cont_clk && !frame_q |-> !serial_clk_oe;
  endproperty
  a_gated_clk: assert property (p_gated_clk)
    else $error("gated serial clock driven outside frame");

  property p_high_byte;
    show && upper_byte_sel_s && !par_fmt |=> result_low_byte[BYTE_W-1:HIGH_W] == '0;
  endproperty
  a_high_byte: assert property (p_high_byte)
    else $error("high byte top bits not zero");

endmodule

`default_nettype wire

// file: tb/adcoi_host_rx.sv
// host-side serial receiver for the converter's open-drain serial port
// assumes the system clock samples the pulled-up wires, far faster than sclk
`default_nettype none

module adcoi_host_rx (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic frame_n_o,
  input wire logic frame_n_oe,
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic dout_o,
  input wire logic dout_oe,
  output int words,
  output logic [15:0] last_word,
  output int last_bits,
  output int idle_falls
);
  timeunit 1ns;
  timeprecision 1ns;
  logic frame_w, sclk_w, dout_w; // resolved wire levels
  logic frame_q, sclk_q; // previous wire levels
  logic [15:0] sh; // receive shift register
  int bits; // bits taken in this frame

  //////////////////////////////////////////////////////////////////////
  // pull-ups: a released line reads high, never the last driven value
  assign frame_w = frame_n_oe ? frame_n_o : 1'b1;
  assign sclk_w = sclk_oe ? sclk_o : 1'b1;
  assign dout_w = dout_oe ? dout_o : 1'b1;

  //////////////////////////////////////////////////////////////////////
  // capture on falling sclk while the strobe is low, msb first
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {frame_q, sclk_q} <= 2'h3;
      sh <= 16'h0000;
      bits <= 0;
      words <= 0;
      last_bits <= 0;
      idle_falls <= 0;
      last_word <= 16'h0000;
    end else begin
      sclk_q <= sclk_w;
      frame_q <= frame_w;
      // data sampled at the fall, so a change after the rise is safe
      if (sclk_q && !sclk_w && !frame_w) begin
        sh <= {sh[14:0], dout_w};
        bits <= bits + 1;
      end
      // falls outside a frame show a free-running clock
      if (sclk_q && !sclk_w && frame_w) begin
        idle_falls <= idle_falls + 1;
      end
      // strobe rise closes the word
      if (!frame_q && frame_w) begin
        words <= words + 1;
        last_word <= sh;
        last_bits <= bits;
        bits <= 0;
      end
    end
  end
endmodule

`default_nettype wire

// file: tb/tb_top.sv
// bench for the converter output interface: pins, serial port, buffer
// assumes a 10 MHz clk and a free master clock of 800 ns period
`default_nettype none

module tb_top;
  import adcoi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset_n = 1'b0, mclk = 1'b0;
  logic start_pulse_n = 1'b1, cs_n = 1'b1, rd_n = 1'b1;
  logic upper_byte_sel = 1'b0, serial_only = 1'b0, clk_style = 1'b0;
  logic [1:0] fmt_sel = FMT_GATED;
  logic [RES_W-1:0] sample_in = 14'h0000;
  logic track_hold, status_n, result_low_oe, result_high_oe;
  logic [BYTE_W-1:0] result_low_byte;
  logic [HIGH_W-1:0] result_high;
  logic serial_frame_n_o, serial_frame_n_oe, serial_clk_o, serial_clk_oe;
  logic serial_dout_o, serial_dout_oe;
  int words, last_bits, idle_falls, mismatches = 0, checks = 0;
  logic [15:0] last_word;
  logic [RES_W-1:0] exp_q[$]; // reference model: words not yet read

  //////////////////////////////////////////////////////////////////////
  // clocks: master clock phase kept unrelated to clk
  always #50 clk = ~clk;
  initial begin
    #137;
    forever #400 mclk = ~mclk;
  end

  adcoi_core dut (.clk, .reset_n, .mclk, .start_pulse_n, .cs_n, .rd_n,
    .upper_byte_sel, .fmt_sel, .serial_only, .clk_style, .sample_in,
    .track_hold, .status_n, .result_low_byte, .result_low_oe,
    .result_high, .result_high_oe, .serial_frame_n_o, .serial_frame_n_oe,
    .serial_clk_o, .serial_clk_oe, .serial_dout_o, .serial_dout_oe);

  adcoi_host_rx hr (.clk, .reset_n, .frame_n_o(serial_frame_n_o),
    .frame_n_oe(serial_frame_n_oe), .sclk_o(serial_clk_o),
    .sclk_oe(serial_clk_oe), .dout_o(serial_dout_o),
    .dout_oe(serial_dout_oe), .words, .last_word, .last_bits,
    .idle_falls);

  //////////////////////////////////////////////////////////////////////
  // helpers: drive 5 ns after the edge, compare with case equality
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // start-pulse conversion; ser: a frame is due, cont: free clock due
  task automatic conv1(input bit ser, input bit cont);
    int w0, dur, c0;
    logic [RES_W-1:0] s;
    w0 = words;
    s = RES_W'($urandom);
    sample_in = s;
    exp_q.push_back(s);
    check(16'(track_hold), 16'h0000);
    start_pulse_n = 1'b0;
    step(2);
    start_pulse_n = 1'b1;
    step(4);
    check(16'(track_hold), 16'h0001);
    dur = 0;
    // bounded wait for the end of hold
    while (track_hold === 1'b1 && dur < 400) begin
      step(1);
      dur++;
    end
    check(16'(dur >= 143 && dur <= 161), 16'h0001);
    step(2);
    check(16'(status_n), 16'h0000);
    if (ser) begin
      check(16'(words), 16'(w0 + 1));
      check(last_word, {2'h0, s});
      check(16'(last_bits), 16'h0010);
      c0 = idle_falls;
      step(24);
      check(16'(idle_falls > c0), 16'(cont));
    end else begin
      check(16'(words), 16'(w0));
    end
  endtask

  // read access; kind 0 low byte, 1 high byte, 2 whole word
  task automatic rdchk(input bit busy, input int kind, input bit pop);
    int n;
    logic [RES_W-1:0] e;
    e = (exp_q.size() > 0) ? exp_q[0] : '0; // dummy read: no word yet
    upper_byte_sel = (kind == 1);
    cs_n = 1'b0;
    rd_n = 1'b0;
    n = 0;
    while (result_low_oe !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    if (busy) begin
      // cs-started conversion stalls the read until busy rises
      step(1);
      check(16'({status_n, track_hold}), 16'h0001);
      n = 0;
      while (status_n !== 1'b1 && n < 400) begin
        step(1);
        n++;
      end
      check(16'(n > 100), 16'h0001);
    end
    step(3);
    if (kind == 0) check(16'(result_low_byte), 16'(e[7:0]));
    if (kind == 1) check(16'(result_low_byte), {10'h000, e[13:8]});
    if (kind == 2) check({result_high, result_low_byte}, {2'h0, e});
    check(16'(result_high_oe), 16'(kind == 2));
    check(16'(status_n), 16'h0001);
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(5);
    if (pop) void'(exp_q.pop_front());
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h635c23a6));
    repeat (4) @(posedge clk);
    #5;
    reset_n = 1'b1;
    check(16'(status_n), 16'h0000);
    step(3);
    // dummy read clears the power-up interrupt; start pin stays high
    rdchk(1'b0, 0, 1'b0);
    // mode 1 in gated, free-running and parallel formats
    for (int i = 0; i < 3; i++) begin
      fmt_sel = 2'(i);
      step(4);
      conv1(i != 2, i == 1);
      if (i == 2) rdchk(1'b0, 2, 1'b1);
      else begin
        rdchk(1'b0, 1, 1'b0);
        rdchk(1'b0, 0, 1'b1);
      end
    end
    // two words fill the buffer, a third start is refused
    conv1(1'b0, 1'b0);
    conv1(1'b0, 1'b0);
    start_pulse_n = 1'b0;
    step(2);
    start_pulse_n = 1'b1;
    step(6);
    check(16'(track_hold), 16'h0000);
    rdchk(1'b0, 2, 1'b1);
    rdchk(1'b0, 2, 1'b1);
    // chip-select mode, byte format: low byte stalls, high byte plain
    fmt_sel = FMT_GATED;
    start_pulse_n = 1'b0;
    step(4);
    exp_q.push_back(RES_W'($urandom));
    sample_in = exp_q[0];
    rdchk(1'b1, 0, 1'b0);
    check(last_word, {2'h0, exp_q[0]});
    rdchk(1'b0, 1, 1'b1);
    // serial-only variant, both clock styles
    serial_only = 1'b1;
    for (int k = 0; k < 2; k++) begin
      clk_style = 1'(k);
      step(4);
      conv1(1'b1, k == 1);
    end
    give_verdict();
  end

  // watchdog: the sequence needs well under a third of this span
  initial begin
    #1000000;
    mismatches++;
    give_verdict();
  end
endmodule

`default_nettype wire
